// ===== ssc_pkg.sv
// Constants, field layouts and state types of the soft start controller.
// Assumes a 250 MHz system clock and an APB master on the register side.
// Contract
// - Keep stored options outside configuration positions
// - Power-up in config position opens 2 s window
// - Both LEDs steady on during window
// - No gesture keeps stored options unchanged
// - Ramp-up max-min-max toggles relay function
// - Start voltage max-min-max toggles phase check
// - Phase toggle flashes green off, red on; code does so when turning the check on, green on, red off when turning it off
// - Failed attempt flashes both, options unchanged
// - Fail on timeout, imprecision or simultaneous moves
// - Selector forces on, off, or automatic control
// - Start voltage 30 to 100 percent, default 30
// - Ramp-up 1 to 30 s, default 5
// - Ramp-down 0 to 30 s, default 0
// - Run relay with start, ramp 100 ms later
// - Stop ramps down to start level, then off
// - Restart during ramp-down ramps up from present
package ssc_pkg;
  // Timebase
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 500000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS = 1000000 / TICK_NS;
  localparam int CFG_WIN_MS = 2000;
  localparam int CFG_WIN_TICKS = CFG_WIN_MS * TICKS_PER_MS;
  localparam int FLASH_MS = 1000;
  localparam int FLASH_TICKS = FLASH_MS * TICKS_PER_MS;
  localparam int BLINK_HALF_US = 62500;
  localparam int BLINK_HALF_TICKS = BLINK_HALF_US * 1000 / TICK_NS;
  localparam int START_DELAY_MS = 100;
  localparam int START_DELAY_TICKS = START_DELAY_MS * TICKS_PER_MS;
  // Potentiometer thresholds on the 8-bit reading
  localparam logic [7:0] POT_HI = 8'hf0;
  localparam logic [7:0] POT_LO = 8'h0f;
  localparam logic [7:0] POT_MID_LO = 8'h8c;
  localparam logic [7:0] POT_MID_HI = 8'hbf;
  localparam logic [7:0] POT_FULL = 8'hff;
  // Ramp ranges, level in permille of mains voltage
  localparam logic [9:0] LVL_FULL = 10'h3e8;
  localparam logic [6:0] USTART_MIN_PCT = 7'h1e;
  localparam logic [6:0] USTART_MAX_PCT = 7'h64;
  localparam logic [6:0] USTART_SPAN_PCT = 7'h46;
  localparam logic [4:0] TSTART_MIN_S = 5'h01;
  localparam logic [4:0] TSTART_SPAN_S = 5'h1e;
  localparam logic [4:0] TSTOP_SPAN_S = 5'h1f;
  localparam logic [6:0] USTART_DEF_PCT = 7'h1e;
  localparam logic [4:0] TSTART_DEF_S = 5'h05;
  localparam logic [4:0] TSTOP_DEF_S = 5'h00;
  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PARAM = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // CTRL fields
  localparam int CTRL_BUS_START = 0;
  localparam int CTRL_OVERRIDE = 1;
  // PARAM fields
  localparam int PAR_USTART_LSB = 0;
  localparam int PAR_TSTART_LSB = 8;
  localparam int PAR_TSTOP_LSB = 16;
  // STATUS fields
  localparam int ST_LEVEL_LSB = 0;
  localparam int ST_OUT_ON = 10;
  localparam int ST_TOP_RELAY = 11;
  localparam int ST_RUN_RELAY = 12;
  localparam int ST_FAULT = 13;
  localparam int ST_RELAY_READY = 14;
  localparam int ST_PHASE_CHECK = 15;
  localparam int ST_CFG_ACTIVE = 16;
  // Selector switch codes
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_ON = 2'h1;
  localparam logic [1:0] SEL_AUTO = 2'h2;
  typedef enum logic [2:0] {CFG_BOOT, CFG_WIN, CFG_FLASH, CFG_RUN} ssc_cfg_t;
  typedef enum logic [2:0] {M_OFF, M_DELAY, M_UP, M_TOP, M_DOWN, M_FAULT} ssc_motor_t;
endpackage : ssc_pkg

// ===== ssc_soft_start.sv
// Soft start controller: configuration window, ramp control and APB registers.
// Assumes pot readings, selector and start input synchronous to clk_sys.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module ssc_soft_start #(
  parameter int TICK_CYC = ssc_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Setting potentiometers and switches
  input wire logic [7:0] potStartVolt,
  input wire logic [7:0] potRampUp,
  input wire logic [7:0] potRampDown,
  input wire logic [1:0] selector,
  input wire logic startCommandIn,
  // Power section status
  input wire logic mainsPresent,
  input wire logic phaseSeqOk,
  // Retained options store
  input wire logic nvRelayReadyIn,
  input wire logic nvPhaseCheckIn,
  output logic nvWrite,
  output logic nvRelayReady,
  output logic nvPhaseCheck,
  // Indicators, relays and power output
  output logic ledGreen,
  output logic ledRed,
  output logic outputOn,
  output logic [9:0] voltLevel,
  output logic topOfRampRelay,
  output logic runReadyRelay,
  output logic phaseFault
);
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end

  logic [31:0] tickCnt_r, tickCnt_nxt;
  logic tick;
  ssc_pkg::ssc_cfg_t cfg_r, cfg_nxt;
  logic [12:0] cfgCnt_r, cfgCnt_nxt;
  logic [7:0] blinkCnt_r, blinkCnt_nxt;
  logic blink_r, blink_nxt;
  logic gUp_r, gUp_nxt, gSv_r, gSv_nxt;
  logic flashG_r, flashG_nxt, flashR_r, flashR_nxt;
  logic relayReady_r, relayReady_nxt, phaseChk_r, phaseChk_nxt;
  logic nvWrite_nxt, ledG_nxt, ledR_nxt;
  ssc_pkg::ssc_motor_t m_r, m_nxt;
  logic [9:0] level_r, level_nxt;
  logic [15:0] acc_r, acc_nxt;
  logic [7:0] dly_r, dly_nxt;
  logic outOn_nxt, topRel_nxt, runRel_nxt, fault_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [6:0] parU_r, parU_nxt;
  logic [4:0] parT_r, parT_nxt, parS_r, parS_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic upMax, upMin, svMax, svMin, stopMid, inCfgPos;
  logic [6:0] uPct;
  logic [4:0] tStartS, tStopS;
  logic [9:0] uStartPm, span;
  logic [15:0] upTicks, downTicks;
  logic start;

  // Pot end positions and ramp-down middle band by fixed thresholds
  assign upMax = potRampUp >= ssc_pkg::POT_HI;
  assign upMin = potRampUp <= ssc_pkg::POT_LO;
  assign svMax = potStartVolt >= ssc_pkg::POT_HI;
  assign svMin = potStartVolt <= ssc_pkg::POT_LO;
  assign stopMid = potRampDown >= ssc_pkg::POT_MID_LO && potRampDown <= ssc_pkg::POT_MID_HI;
  assign inCfgPos = upMax && svMax && stopMid;

  // Setting scaling, from pots or from the bus parameter register
  always_comb
  begin
    logic [14:0] prodU;
    logic [12:0] prodT;
    logic [12:0] prodS;
    prodU = 15'(potStartVolt) * 15'(ssc_pkg::USTART_SPAN_PCT);
    prodT = 13'(potRampUp) * 13'(ssc_pkg::TSTART_SPAN_S);
    prodS = 13'(potRampDown) * 13'(ssc_pkg::TSTOP_SPAN_S);
    if (ctrl_r[ssc_pkg::CTRL_OVERRIDE])
    begin
      uPct = parU_r;
      tStartS = parT_r;
      tStopS = parS_r;
    end
    else
    begin
      uPct = (potStartVolt == ssc_pkg::POT_FULL) ? ssc_pkg::USTART_MAX_PCT
           : ssc_pkg::USTART_MIN_PCT + prodU[14:8];
      tStartS = ssc_pkg::TSTART_MIN_S + prodT[12:8];
      tStopS = prodS[12:8];
    end
    uStartPm = 10'(uPct) * 10'h00a;
    span = ssc_pkg::LVL_FULL - uStartPm;
    upTicks = 16'(tStartS) * 16'(1000 * ssc_pkg::TICKS_PER_MS);
    downTicks = 16'(tStopS) * 16'(1000 * ssc_pkg::TICKS_PER_MS);
  end

  // Selector switch decides where the start command comes from
  always_comb
  begin
    unique case (selector)
      ssc_pkg::SEL_ON: start = 1'b1;
      ssc_pkg::SEL_AUTO: start = ctrl_r[ssc_pkg::CTRL_BUS_START] | startCommandIn;
      default: start = 1'b0;
    endcase
  end

  // Half-millisecond timebase
  always_comb
  begin
    tick = tickCnt_r == 32'(TICK_CYC - 1);
    tickCnt_nxt = tick ? 32'h0 : tickCnt_r + 32'h1;
  end

  // Configuration window, gesture tracking and indicator LEDs
  always_comb
  begin
    cfg_nxt = cfg_r;
    cfgCnt_nxt = cfgCnt_r;
    gUp_nxt = gUp_r;
    gSv_nxt = gSv_r;
    flashG_nxt = flashG_r;
    flashR_nxt = flashR_r;
    relayReady_nxt = relayReady_r;
    phaseChk_nxt = phaseChk_r;
    nvWrite_nxt = 1'b0;
    blinkCnt_nxt = blinkCnt_r;
    blink_nxt = blink_r;
    if (tick)
    begin
      cfgCnt_nxt = cfgCnt_r + 13'h1;
      blinkCnt_nxt = blinkCnt_r + 8'h1;
      if (blinkCnt_r == 8'(ssc_pkg::BLINK_HALF_TICKS - 1))
      begin
        blinkCnt_nxt = 8'h0;
        blink_nxt = ~blink_r;
      end
    end
    unique case (cfg_r)
      ssc_pkg::CFG_BOOT:
      begin
        relayReady_nxt = nvRelayReadyIn;
        phaseChk_nxt = nvPhaseCheckIn;
        cfgCnt_nxt = 13'h0;
        cfg_nxt = inCfgPos ? ssc_pkg::CFG_WIN : ssc_pkg::CFG_RUN;
      end
      ssc_pkg::CFG_WIN:
      begin
        if (!gUp_r && upMin)
          gUp_nxt = 1'b1;
        if (!gSv_r && svMin)
          gSv_nxt = 1'b1;
        if ((!upMax && !svMax) || !stopMid)
        begin
          flashG_nxt = 1'b1;
          flashR_nxt = 1'b1;
          cfg_nxt = ssc_pkg::CFG_FLASH;
        end
        else if (gUp_r && upMax)
        begin
          relayReady_nxt = ~relayReady_r;
          flashG_nxt = relayReady_r;
          flashR_nxt = ~relayReady_r;
          nvWrite_nxt = 1'b1;
          cfg_nxt = ssc_pkg::CFG_FLASH;
        end
        else if (gSv_r && svMax)
        begin
          phaseChk_nxt = ~phaseChk_r;
          flashG_nxt = phaseChk_r;
          flashR_nxt = ~phaseChk_r;
          nvWrite_nxt = 1'b1;
          cfg_nxt = ssc_pkg::CFG_FLASH;
        end
        else if (tick && cfgCnt_r == 13'(ssc_pkg::CFG_WIN_TICKS - 1))
        begin
          flashG_nxt = gUp_r | gSv_r;
          flashR_nxt = gUp_r | gSv_r;
          cfg_nxt = (gUp_r | gSv_r) ? ssc_pkg::CFG_FLASH : ssc_pkg::CFG_RUN;
        end
        if (cfg_nxt != ssc_pkg::CFG_WIN)
        begin
          cfgCnt_nxt = 13'h0;
          blinkCnt_nxt = 8'h0;
          blink_nxt = 1'b1;
        end
      end
      ssc_pkg::CFG_FLASH:
      begin
        if (tick && cfgCnt_r == 13'(ssc_pkg::FLASH_TICKS - 1))
          cfg_nxt = ssc_pkg::CFG_RUN;
      end
      ssc_pkg::CFG_RUN:
        cfg_nxt = ssc_pkg::CFG_RUN;
      default:
        cfg_nxt = ssc_pkg::CFG_RUN;
    endcase
    unique case (cfg_nxt)
      ssc_pkg::CFG_WIN:
      begin
        ledG_nxt = 1'b1;
        ledR_nxt = 1'b1;
      end
      ssc_pkg::CFG_FLASH:
      begin
        ledG_nxt = flashG_nxt & blink_nxt;
        ledR_nxt = flashR_nxt & blink_nxt;
      end
      default:
      begin
        ledG_nxt = outOn_nxt;
        ledR_nxt = fault_nxt;
      end
    endcase
  end

  // Motor ramp sequencer, held off until configuration is over
  always_comb
  begin
    logic [15:0] sum;
    sum = acc_r + 16'(span);
    m_nxt = m_r;
    level_nxt = level_r;
    acc_nxt = acc_r;
    dly_nxt = dly_r;
    unique case (m_r)
      ssc_pkg::M_OFF:
      begin
        level_nxt = 10'h0;
        dly_nxt = 8'h0;
        if (start && cfg_r == ssc_pkg::CFG_RUN)
          m_nxt = ssc_pkg::M_DELAY;
      end
      ssc_pkg::M_DELAY:
      begin
        if (!start)
          m_nxt = ssc_pkg::M_OFF;
        else if (tick)
        begin
          dly_nxt = dly_r + 8'h1;
          if (dly_r == 8'(ssc_pkg::START_DELAY_TICKS - 1))
          begin
            acc_nxt = 16'h0;
            level_nxt = uStartPm;
            if (!mainsPresent || (phaseChk_r && !phaseSeqOk))
              m_nxt = ssc_pkg::M_FAULT;
            else
              m_nxt = ssc_pkg::M_UP;
          end
        end
      end
      ssc_pkg::M_UP:
      begin
        if (!start)
        begin
          acc_nxt = 16'h0;
          m_nxt = ssc_pkg::M_DOWN;
        end
        else if (level_r >= ssc_pkg::LVL_FULL)
        begin
          level_nxt = ssc_pkg::LVL_FULL;
          m_nxt = ssc_pkg::M_TOP;
        end
        else if (tick)
        begin
          acc_nxt = sum;
          if (sum >= upTicks)
          begin
            acc_nxt = sum - upTicks;
            level_nxt = level_r + 10'h1;
          end
        end
      end
      ssc_pkg::M_TOP:
      begin
        acc_nxt = 16'h0;
        if (!start)
          m_nxt = ssc_pkg::M_DOWN;
      end
      ssc_pkg::M_DOWN:
      begin
        if (start)
        begin
          acc_nxt = 16'h0;
          m_nxt = ssc_pkg::M_UP;
        end
        else if (tStopS == 5'h0 || level_r <= uStartPm)
          m_nxt = ssc_pkg::M_OFF;
        else if (tick)
        begin
          acc_nxt = sum;
          if (sum >= downTicks)
          begin
            acc_nxt = sum - downTicks;
            level_nxt = level_r - 10'h1;
          end
        end
      end
      ssc_pkg::M_FAULT:
      begin
        level_nxt = 10'h0;
        if (!start)
          m_nxt = ssc_pkg::M_OFF;
      end
      default:
        m_nxt = ssc_pkg::M_OFF;
    endcase
    if (m_nxt == ssc_pkg::M_OFF || m_nxt == ssc_pkg::M_FAULT)
      level_nxt = 10'h0;
    outOn_nxt = m_nxt == ssc_pkg::M_UP || m_nxt == ssc_pkg::M_TOP || m_nxt == ssc_pkg::M_DOWN;
    topRel_nxt = m_nxt == ssc_pkg::M_TOP;
    fault_nxt = m_nxt == ssc_pkg::M_FAULT;
    if (relayReady_r)
      runRel_nxt = cfg_r == ssc_pkg::CFG_RUN && !fault_nxt;
    else
      runRel_nxt = outOn_nxt || m_nxt == ssc_pkg::M_DELAY;
  end

  // APB slave: one wait state, write takes effect with pready high
  always_comb
  begin
    logic acc;
    acc = psel && penable && pready;
    ctrl_nxt = ctrl_r;
    parU_nxt = parU_r;
    parT_nxt = parT_r;
    parS_nxt = parS_r;
    prdata_nxt = prdata;
    pready_nxt = psel && penable && !pready;
    pslverr_nxt = 1'b0;
    if (psel && penable && !pready)
    begin
      prdata_nxt = 32'h0;
      pslverr_nxt = !(paddr == ssc_pkg::ADDR_CTRL || paddr == ssc_pkg::ADDR_PARAM
                      || paddr == ssc_pkg::ADDR_STATUS);
      unique case (paddr)
        ssc_pkg::ADDR_CTRL: prdata_nxt[1:0] = ctrl_r;
        ssc_pkg::ADDR_PARAM:
        begin
          prdata_nxt[ssc_pkg::PAR_USTART_LSB +: 7] = parU_r;
          prdata_nxt[ssc_pkg::PAR_TSTART_LSB +: 5] = parT_r;
          prdata_nxt[ssc_pkg::PAR_TSTOP_LSB +: 5] = parS_r;
        end
        ssc_pkg::ADDR_STATUS:
        begin
          prdata_nxt[ssc_pkg::ST_LEVEL_LSB +: 10] = level_r;
          prdata_nxt[ssc_pkg::ST_OUT_ON] = outputOn;
          prdata_nxt[ssc_pkg::ST_TOP_RELAY] = topOfRampRelay;
          prdata_nxt[ssc_pkg::ST_RUN_RELAY] = runReadyRelay;
          prdata_nxt[ssc_pkg::ST_FAULT] = phaseFault;
          prdata_nxt[ssc_pkg::ST_RELAY_READY] = relayReady_r;
          prdata_nxt[ssc_pkg::ST_PHASE_CHECK] = phaseChk_r;
          prdata_nxt[ssc_pkg::ST_CFG_ACTIVE] = cfg_r != ssc_pkg::CFG_RUN;
        end
        default: prdata_nxt = 32'h0;
      endcase
    end
    if (acc && pwrite && paddr == ssc_pkg::ADDR_CTRL)
      ctrl_nxt = pwdata[1:0];
    if (acc && pwrite && paddr == ssc_pkg::ADDR_PARAM)
    begin
      parU_nxt = pwdata[ssc_pkg::PAR_USTART_LSB +: 7];
      parT_nxt = pwdata[ssc_pkg::PAR_TSTART_LSB +: 5];
      parS_nxt = pwdata[ssc_pkg::PAR_TSTOP_LSB +: 5];
    end
  end

  // State registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      tickCnt_r <= 32'h0;
      cfg_r <= ssc_pkg::CFG_BOOT;
      cfgCnt_r <= 13'h0;
      blinkCnt_r <= 8'h0;
      blink_r <= 1'b1;
      gUp_r <= 1'b0;
      gSv_r <= 1'b0;
      flashG_r <= 1'b0;
      flashR_r <= 1'b0;
      relayReady_r <= 1'b0;
      phaseChk_r <= 1'b0;
      nvWrite <= 1'b0;
      ledGreen <= 1'b0;
      ledRed <= 1'b0;
      m_r <= ssc_pkg::M_OFF;
      level_r <= 10'h0;
      acc_r <= 16'h0;
      dly_r <= 8'h0;
      outputOn <= 1'b0;
      topOfRampRelay <= 1'b0;
      runReadyRelay <= 1'b0;
      phaseFault <= 1'b0;
      ctrl_r <= 2'h0;
      parU_r <= ssc_pkg::USTART_DEF_PCT;
      parT_r <= ssc_pkg::TSTART_DEF_S;
      parS_r <= ssc_pkg::TSTOP_DEF_S;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      tickCnt_r <= tickCnt_nxt;
      cfg_r <= cfg_nxt;
      cfgCnt_r <= cfgCnt_nxt;
      blinkCnt_r <= blinkCnt_nxt;
      blink_r <= blink_nxt;
      gUp_r <= gUp_nxt;
      gSv_r <= gSv_nxt;
      flashG_r <= flashG_nxt;
      flashR_r <= flashR_nxt;
      relayReady_r <= relayReady_nxt;
      phaseChk_r <= phaseChk_nxt;
      nvWrite <= nvWrite_nxt;
      ledGreen <= ledG_nxt;
      ledRed <= ledR_nxt;
      m_r <= m_nxt;
      level_r <= level_nxt;
      acc_r <= acc_nxt;
      dly_r <= dly_nxt;
      outputOn <= outOn_nxt;
      topOfRampRelay <= topRel_nxt;
      runReadyRelay <= runRel_nxt;
      phaseFault <= fault_nxt;
      ctrl_r <= ctrl_nxt;
      parU_r <= parU_nxt;
      parT_r <= parT_nxt;
      parS_r <= parS_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // Options presented to the retention store, and the output level
  assign nvRelayReady = relayReady_r;
  assign nvPhaseCheck = phaseChk_r;
  assign voltLevel = level_r;
endmodule : ssc_soft_start

// ===== ssc_soft_start_chk.sv
// Assertion checker of the soft start controller: window, options, flash and ramp.
// Sees only the controller's ports; attached by the bind at the foot.
`timescale 1ns/1ns
module ssc_soft_start_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Settings
  input wire logic [7:0] potStartVolt,
  input wire logic [7:0] potRampUp,
  input wire logic [7:0] potRampDown,
  input wire logic [1:0] selector,
  // Options store
  input wire logic nvWrite,
  input wire logic nvRelayReady,
  input wire logic nvPhaseCheck,
  // Indicators and output
  input wire logic ledGreen,
  input wire logic ledRed,
  input wire logic outputOn,
  input wire logic [9:0] voltLevel,
  input wire logic topOfRampRelay,
  input wire logic runReadyRelay,
  input wire logic phaseFault
);
  logic cfgPos;
  logic selRun;
  logic [1:0] upCnt_r;
  logic [1:0] upCnt_nxt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Window pot positions and selector positions that allow a start
  assign cfgPos = potRampUp >= ssc_pkg::POT_HI && potStartVolt >= ssc_pkg::POT_HI
    && potRampDown >= ssc_pkg::POT_MID_LO && potRampDown <= ssc_pkg::POT_MID_HI;
  assign selRun = selector == ssc_pkg::SEL_ON || selector == ssc_pkg::SEL_AUTO;
  // Edges since reset release, saturating; boot load is over at 3
  always_comb
  begin
    upCnt_nxt = sys_rst ? 2'h0 : (upCnt_r == 2'h3) ? upCnt_r : upCnt_r + 2'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    upCnt_r <= upCnt_nxt;
  end
  sequence sBoot;
    $fell(sys_rst) ##0 cfgPos;
  endsequence
  sequence sBothLit;
    (ledGreen && ledRed) [*8];
  endsequence
  AST_WIN_LEDS: assert property (sBoot |-> ##2 sBothLit)
    else $error("window LEDs not lit");
  AST_NV_KEEP: assert property (upCnt_r == 2'h3
    && ($changed(nvRelayReady) || $changed(nvPhaseCheck)) |-> nvWrite)
    else $error("option changed without store");
  AST_NV_ONE: assert property (nvWrite |-> $onehot({nvRelayReady, nvPhaseCheck}
    ^ {$past(nvRelayReady), $past(nvPhaseCheck)})) else $error("store without one toggle");
  AST_RUN_FLASH: assert property (nvWrite && $changed(nvRelayReady)
    |-> ##2 (ledRed == nvRelayReady && ledGreen != nvRelayReady) [*8])
    else $error("relay flash colour");
  AST_PH_FLASH: assert property (nvWrite && $changed(nvPhaseCheck)
    |-> ##2 (ledRed == nvPhaseCheck && ledGreen != nvPhaseCheck) [*8])
    else $error("phase flash colour");
  AST_START_DLY: assert property ($rose(outputOn) |-> $past(runReadyRelay, 100))
    else $error("output before relay delay");
  AST_START_LVL: assert property ($rose(outputOn)
    |-> voltLevel >= 10'h12c && voltLevel <= ssc_pkg::LVL_FULL) else $error("start level");
  AST_TOR_FULL: assert property ($rose(topOfRampRelay)
    |-> outputOn && voltLevel == ssc_pkg::LVL_FULL) else $error("top relay below full");
  AST_LVL_STEP: assert property (outputOn && $past(outputOn) |->
    voltLevel == $past(voltLevel) || voltLevel == $past(voltLevel) + 10'h1
    || voltLevel + 10'h1 == $past(voltLevel)) else $error("level step");
  AST_SEL_RUN: assert property ($rose(outputOn) |-> $past(selRun))
    else $error("start in off position");
  AST_FAULT_OFF: assert property (phaseFault |-> !outputOn && !topOfRampRelay)
    else $error("output on in fault");
endmodule : ssc_soft_start_chk
bind ssc_soft_start ssc_soft_start_chk ssc_soft_start_chk_inst (
  .clk_sys, .sys_rst, .potStartVolt, .potRampUp, .potRampDown, .selector,
  .nvWrite, .nvRelayReady, .nvPhaseCheck, .ledGreen, .ledRed, .outputOn,
  .voltLevel, .topOfRampRelay, .runReadyRelay, .phaseFault
);

// ===== ssc_operator_model.sv
// Operator model: the three setting pots and the retained option store.
// Bench calls its tasks right after a rising edge.
`timescale 1ns/1ns
module ssc_operator_model (
  // Clock
  input wire logic clk_sys,
  // Store side of the controller
  input wire logic nvWrite,
  input wire logic nvRelayReady,
  input wire logic nvPhaseCheck,
  output logic nvRelayReadyIn,
  output logic nvPhaseCheckIn,
  // Setting pots
  output logic [7:0] potStartVolt,
  output logic [7:0] potRampUp,
  output logic [7:0] potRampDown
);
  // Factory options, pots at minimum
  initial
  begin
    nvRelayReadyIn = 1'b0;
    nvPhaseCheckIn = 1'b0;
    potStartVolt = 8'h00;
    potRampUp = 8'h00;
    potRampDown = 8'h00;
  end
  // Store keeps its value across every reset of the controller
  always @(posedge clk_sys)
  begin
    if (nvWrite)
    begin
      nvRelayReadyIn <= nvRelayReady;
      nvPhaseCheckIn <= nvPhaseCheck;
    end
  end
  // Move the pots together just after an edge
  task setPots(input logic [7:0] sv, input logic [7:0] ru, input logic [7:0] rd);
    @(posedge clk_sys);
    potStartVolt <= sv;
    potRampUp <= ru;
    potRampDown <= rd;
  endtask : setPots
  // Both max, ramp-down near two thirds, off its ends
  task cfgPos();
    setPots(8'hff, 8'hff, 8'ha6);
  endtask : cfgPos
  // Max to min and back on the chosen pots; both together is refused
  task gesture(input logic ru, input logic sv);
    repeat (40) @(posedge clk_sys);
    setPots(sv ? 8'h00 : 8'hff, ru ? 8'h00 : 8'hff, 8'ha6);
    repeat (40) @(posedge clk_sys);
    setPots(8'hff, 8'hff, 8'ha6);
  endtask : gesture
endmodule : ssc_operator_model

// ===== test_soft_start_config_and_ramp_settings.sv
// Bench of the soft start controller: configuration gestures, APB and ramps.
// Uses the operator model for pots and store; tick shortened by TICK_CYC.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
`define WAITC(c, n) begin wk = 0; while ((c) !== 1'b1 && wk < (n)) begin \
  @(posedge clk_sys); wk++; end if ((c) !== 1'b1) begin fail_count++; results(); end end
module test_soft_start_config_and_ramp_settings;
  localparam int TC = 6;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, potStartVolt, potRampUp, potRampDown;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] selector;
  logic startCommandIn, mainsPresent, phaseSeqOk, nvRelayReadyIn, nvPhaseCheckIn;
  logic nvWrite, nvRelayReady, nvPhaseCheck, ledGreen, ledRed, outputOn;
  logic topOfRampRelay, runReadyRelay, phaseFault;
  logic [9:0] voltLevel;
  int fail_count, n_tests, wk, nvCount;
  ssc_soft_start #(.TICK_CYC(TC)) ssc_soft_start_inst (.clk_sys, .sys_rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .potStartVolt, .potRampUp,
    .potRampDown, .selector, .startCommandIn, .mainsPresent, .phaseSeqOk, .nvRelayReadyIn,
    .nvPhaseCheckIn, .nvWrite, .nvRelayReady, .nvPhaseCheck, .ledGreen, .ledRed, .outputOn,
    .voltLevel, .topOfRampRelay, .runReadyRelay, .phaseFault);
  ssc_operator_model ssc_operator_model_inst (.clk_sys, .nvWrite, .nvRelayReady,
    .nvPhaseCheck, .nvRelayReadyIn, .nvPhaseCheckIn, .potStartVolt, .potRampUp,
    .potRampDown);
  // 250 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Count store pulses
  always @(posedge clk_sys)
  begin
    if (nvWrite !== 1'b0)
      nvCount++;
  end
  // Counts, verdict and end of run
  task results();
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // One APB transfer; result left in rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Reset for 6 cycles with pots in window or minimum positions
  task pwrUp(input logic cfg);
    if (cfg)
      ssc_operator_model_inst.cfgPos();
    else
      ssc_operator_model_inst.setPots(8'h00, 8'h00, 8'h00);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (12) @(posedge clk_sys);
    nvCount = 0;
  endtask : pwrUp
  // First blink half lit as given, second half dark
  task flash(input logic g, input logic r);
    repeat (62 * TC) @(posedge clk_sys);
    `CHK("flashLit", {g, r}, {ledGreen, ledRed})
    repeat (125 * TC) @(posedge clk_sys);
    `CHK("flashDark", 2'h0, {ledGreen, ledRed})
  endtask : flash
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    selector = ssc_pkg::SEL_AUTO;
    startCommandIn = 1'b0;
    mainsPresent = 1'b1;
    phaseSeqOk = 1'b1;
    fail_count = 0;
    n_tests = 0;
    // Ramp-up gesture: relay to ready, red flash
    pwrUp(1'b1);
    `CHK("winLeds", 2'h3, {ledGreen, ledRed})
    ssc_operator_model_inst.gesture(1'b1, 1'b0);
    `WAITC(nvWrite, 50)
    `CHK("relay", 2'h2, {nvRelayReady, nvPhaseCheck})
    flash(1'b0, 1'b1);
    // Start voltage gesture: check enabled, red flash
    pwrUp(1'b1);
    `CHK("kept", 2'h2, {nvRelayReady, nvPhaseCheck})
    ssc_operator_model_inst.gesture(1'b0, 1'b1);
    `WAITC(nvWrite, 50)
    `CHK("phase", 2'h3, {nvRelayReady, nvPhaseCheck})
    flash(1'b0, 1'b1);
    // Relay back to running, green flash
    pwrUp(1'b1);
    ssc_operator_model_inst.gesture(1'b1, 1'b0);
    `WAITC(nvWrite, 50)
    `CHK("relay", 2'h1, {nvRelayReady, nvPhaseCheck})
    flash(1'b1, 1'b0);
    // Both pots moved together: refused
    pwrUp(1'b1);
    ssc_operator_model_inst.gesture(1'b1, 1'b1);
    flash(1'b1, 1'b1);
    `CHK("noStore", 32'h0, nvCount)
    `CHK("opts", 2'h1, {nvRelayReady, nvPhaseCheck})
    // Window runs out untouched
    pwrUp(1'b1);
    repeat (4000 * TC) @(posedge clk_sys);
    `CHK("expired", 2'h0, {ledGreen, ledRed})
    `CHK("noStore", 32'h0, nvCount)
    `CHK("opts", 2'h1, {nvRelayReady, nvPhaseCheck})
    // Normal power-up, pots at minimum; registers
    pwrUp(1'b0);
    `CHK("noWin", 2'h0, {ledGreen, ledRed})
    apb(1'b0, ssc_pkg::ADDR_PARAM, 32'h0);
    `CHK("param", 32'h0000051e, rd)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped", 1'b1, er)
    // Selector off blocks the start command
    selector <= ssc_pkg::SEL_OFF;
    startCommandIn <= 1'b1;
    repeat (50) @(posedge clk_sys);
    `CHK("selOff", 1'b0, runReadyRelay)
    selector <= ssc_pkg::SEL_AUTO;
    `WAITC(runReadyRelay, 4)
    `WAITC(outputOn, 210 * TC)
    `CHK("delay", 1'b1, wk > 190 * TC)
    `CHK("ustart", 10'h12c, voltLevel)
    `WAITC(topOfRampRelay, 2100 * TC)
    `CHK("rampUp", 1'b1, wk > 1900 * TC)
    `CHK("full", 10'h3e8, voltLevel)
    startCommandIn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK("stopped", 2'h0, {outputOn, topOfRampRelay})
    // Bus start with 1 s ramps, stop, restart mid ramp-down
    apb(1'b1, ssc_pkg::ADDR_PARAM, 32'h0001011e);
    apb(1'b1, ssc_pkg::ADDR_CTRL, 32'h3);
    `WAITC(topOfRampRelay, 2400 * TC)
    apb(1'b1, ssc_pkg::ADDR_CTRL, 32'h2);
    repeat (100 * TC) @(posedge clk_sys);
    `CHK("down", 1'b1, voltLevel < 10'h3e8 && voltLevel > 10'h190)
    apb(1'b1, ssc_pkg::ADDR_CTRL, 32'h3);
    `WAITC(topOfRampRelay, 200 * TC)
    apb(1'b1, ssc_pkg::ADDR_CTRL, 32'h2);
    `WAITC(!outputOn, 2100 * TC)
    `CHK("rampDown", 1'b1, wk > 1900 * TC)
    // Wrong phase order with the check on: fault, cleared by off
    phaseSeqOk <= 1'b0;
    selector <= ssc_pkg::SEL_ON;
    `WAITC(phaseFault, 220 * TC)
    selector <= ssc_pkg::SEL_OFF;
    phaseSeqOk <= 1'b1;
    `WAITC(!phaseFault, 4)
    // Forced on without mains: fault
    mainsPresent <= 1'b0;
    selector <= ssc_pkg::SEL_ON;
    `WAITC(phaseFault, 220 * TC)
    `CHK("fault", 2'h0, {outputOn, topOfRampRelay})
    results();
  end
endmodule : test_soft_start_config_and_ramp_settings
